// >>> verilog/sbsm_pkg.sv
package sbsm_pkg;

  // ----------------------------------------------------------------
  // port counts and numbering
  // ----------------------------------------------------------------
  localparam int NUM_MST = 6;
  localparam int NUM_SLV = 6;

  localparam logic [2:0] MST_GEN_DMA  = 3'h0;
  localparam logic [2:0] MST_USB_DMA  = 3'h1;
  localparam logic [2:0] MST_LCD_DMA  = 3'h2;
  localparam logic [2:0] MST_PER_DMA  = 3'h3;
  localparam logic [2:0] MST_CPU_INST = 3'h4;
  localparam logic [2:0] MST_CPU_DATA = 3'h5;

  localparam logic [2:0] SLV_ROM      = 3'h0;
  localparam logic [2:0] SLV_SRAM     = 3'h1;
  localparam logic [2:0] SLV_LCD_CFG  = 3'h2;
  localparam logic [2:0] SLV_USB_RAM  = 3'h3;
  localparam logic [2:0] SLV_EXT_MEM  = 3'h4;
  localparam logic [2:0] SLV_PER_BRG  = 3'h5;

  // ----------------------------------------------------------------
  // address map: 16 banks of 256 MB, sub-areas of 1 MB in bank 0
  // ----------------------------------------------------------------
  localparam logic [3:0] BANK_INTERNAL  = 4'h0;
  localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [3:0] BANK_EXT_LAST  = 4'h8;
  localparam logic [3:0] BANK_PERIPH    = 4'hF;

  localparam logic [7:0] SUB_BOOT       = 8'h00;
  localparam logic [7:0] SUB_SRAM_FIRST = 8'h01;
  localparam logic [7:0] SUB_SRAM_LAST  = 8'h03;
  localparam logic [7:0] SUB_ROM        = 8'h04;
  localparam logic [7:0] SUB_LCD_CFG    = 8'h05;
  localparam logic [7:0] SUB_USB_RAM    = 8'h06;

  // ----------------------------------------------------------------
  // transfer sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // reset values and default path matrix (bit m = master m allowed)
  // ----------------------------------------------------------------
  localparam logic [2:0] LAST_RST = 3'h5;
  localparam logic [5:0] PATH_ROM_DEF     = 6'h3B;
  localparam logic [5:0] PATH_SRAM_DEF    = 6'h3F;
  localparam logic [5:0] PATH_LCD_CFG_DEF = 6'h30;
  localparam logic [5:0] PATH_USB_RAM_DEF = 6'h30;
  localparam logic [5:0] PATH_EXT_MEM_DEF = 6'h3F;
  localparam logic [5:0] PATH_PER_BRG_DEF = 6'h05;

  typedef enum logic [0:0] {
    SBSM_ARB_RR    = 1'b0,
    SBSM_ARB_FIXED = 1'b1
  } sbsm_arb_mode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        write;
    logic [2:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sbsm_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } sbsm_rsp_t;

  typedef struct packed {
    logic       ok;
    logic [2:0] slv;
  } sbsm_dec_t;

endpackage

// >>> verilog/sbsm_matrix.sv
// Contract
// - six masters may transfer concurrently when targeting different free slaves
// - each master has its own decoder, all sharing one address map
// - each slave has its own arbiter, policy selectable per slave
// - masters 0..5 are gen DMA, USB DMA, LCD DMA, periph DMA, CPU inst, data
// - slaves 0..5 are ROM, SRAM, LCD config, USB RAM, external memory, bridge
// - unused master-slave paths are removed so the master cannot reach that slave
// - LCD config and USB RAM are reachable only from the two CPU masters
// - the USB DMA master cannot reach the peripheral bridge
// - byte, half-word and word transfers are all routed
// - address space splits into sixteen 256 MB banks selected by top nibble
// - bank 0 internal, banks 1 to 8 external memory, bank 15 bridge
// - accesses to unused areas end with an error response
// - address zero mapping follows per-master remap bit and sampled boot level
module sbsm_matrix #(
  parameter logic [5:0]           PATH_ROM     = sbsm_pkg::PATH_ROM_DEF,
  parameter logic [5:0]           PATH_SRAM    = sbsm_pkg::PATH_SRAM_DEF,
  parameter logic [5:0]           PATH_LCD_CFG = sbsm_pkg::PATH_LCD_CFG_DEF,
  parameter logic [5:0]           PATH_USB_RAM = sbsm_pkg::PATH_USB_RAM_DEF,
  parameter logic [5:0]           PATH_EXT_MEM = sbsm_pkg::PATH_EXT_MEM_DEF,
  parameter logic [5:0]           PATH_PER_BRG = sbsm_pkg::PATH_PER_BRG_DEF,
  parameter logic [5:0]           ARB_FIXED    = 6'h00
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               boot_select_level,
  input  wire logic [5:0]         remap_control_bit,
  input  sbsm_pkg::sbsm_req_t     mst_req [sbsm_pkg::NUM_MST],
  output sbsm_pkg::sbsm_rsp_t     mst_rsp [sbsm_pkg::NUM_MST],
  output sbsm_pkg::sbsm_req_t     slv_req [sbsm_pkg::NUM_SLV],
  input  sbsm_pkg::sbsm_rsp_t     slv_rsp [sbsm_pkg::NUM_SLV]
);

  // ----------------------------------------------------------------
  // path matrix
  // ----------------------------------------------------------------
  // bit m is master m
  localparam logic [5:0] PATH [sbsm_pkg::NUM_SLV] = '{
    PATH_ROM, PATH_SRAM, PATH_LCD_CFG, PATH_USB_RAM, PATH_EXT_MEM, PATH_PER_BRG
  };

  // ----------------------------------------------------------------
  // shared address decoder
  // ----------------------------------------------------------------
  function automatic sbsm_pkg::sbsm_dec_t decode(
    input logic [31:0] addr,
    input logic        remap,
    input logic        boot
  );
    sbsm_pkg::sbsm_dec_t d;
    logic [3:0]          bank;
    logic [7:0]          sub;
    d    = '{ok: 1'b0, slv: sbsm_pkg::SLV_ROM};
    bank = addr[31:28];
    sub  = addr[27:20];
    if (bank == sbsm_pkg::BANK_INTERNAL) begin
      // address zero follows remap and boot level
      if (sub == sbsm_pkg::SUB_BOOT) begin
        d.ok  = 1'b1;
        d.slv = remap ? sbsm_pkg::SLV_SRAM :
                boot  ? sbsm_pkg::SLV_ROM  : sbsm_pkg::SLV_EXT_MEM;
      end else if (sub >= sbsm_pkg::SUB_SRAM_FIRST && sub <= sbsm_pkg::SUB_SRAM_LAST) begin
        d = '{ok: 1'b1, slv: sbsm_pkg::SLV_SRAM};
      end else if (sub == sbsm_pkg::SUB_ROM) begin
        d = '{ok: 1'b1, slv: sbsm_pkg::SLV_ROM};
      end else if (sub == sbsm_pkg::SUB_LCD_CFG) begin
        d = '{ok: 1'b1, slv: sbsm_pkg::SLV_LCD_CFG};
      end else if (sub == sbsm_pkg::SUB_USB_RAM) begin
        d = '{ok: 1'b1, slv: sbsm_pkg::SLV_USB_RAM};
      end
    end else if (bank >= sbsm_pkg::BANK_EXT_FIRST && bank <= sbsm_pkg::BANK_EXT_LAST) begin
      d = '{ok: 1'b1, slv: sbsm_pkg::SLV_EXT_MEM};
    end else if (bank == sbsm_pkg::BANK_PERIPH) begin
      d = '{ok: 1'b1, slv: sbsm_pkg::SLV_PER_BRG};
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // per-slave arbitration pick: {found, index}
  // ----------------------------------------------------------------
  function automatic logic [3:0] pick(
    input logic [5:0] cand,
    input logic [2:0] last,
    input logic       fixed
  );
    logic [3:0] r;
    logic [2:0] idx;
    r = 4'h0;
    for (int k = 0; k < sbsm_pkg::NUM_MST; k++) begin
      if (fixed) begin
        idx = 3'(k);
      end else begin
        idx = 3'((int'(last) + 1 + k) % sbsm_pkg::NUM_MST);
      end
      if (!r[3] && cand[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // boot level capture
  // ----------------------------------------------------------------
  logic boot_sync1;
  logic boot_sync2;
  logic boot_cap;
  logic boot_done;
  logic [1:0] boot_fill;
  logic next_boot_cap;
  logic next_boot_done;
  logic [1:0] next_boot_fill;

  // boot level latched once after reset release
  always_comb begin
    // capture waits until the synchroniser holds a real pin sample
    next_boot_fill = {boot_fill[0], 1'b1};
    next_boot_done = boot_done | boot_fill[1];
    next_boot_cap  = boot_done ? boot_cap : boot_sync2;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_sync1 <= 1'b0;
      boot_sync2 <= 1'b0;
      boot_cap   <= 1'b0;
      boot_done  <= 1'b0;
      boot_fill  <= 2'h0;
    end else begin
      boot_sync1 <= boot_select_level;
      boot_sync2 <= boot_sync1;
      boot_cap   <= next_boot_cap;
      boot_done  <= next_boot_done;
      boot_fill  <= next_boot_fill;
    end
  end

  // ----------------------------------------------------------------
  // routing state
  // ----------------------------------------------------------------
  logic [5:0]          busy;
  logic [2:0]          owner      [sbsm_pkg::NUM_SLV];
  logic [2:0]          last       [sbsm_pkg::NUM_SLV];
  logic [5:0]          next_busy;
  logic [2:0]          next_owner [sbsm_pkg::NUM_SLV];
  logic [2:0]          next_last  [sbsm_pkg::NUM_SLV];
  sbsm_pkg::sbsm_req_t next_slv_req [sbsm_pkg::NUM_SLV];
  sbsm_pkg::sbsm_rsp_t next_mst_rsp [sbsm_pkg::NUM_MST];
  sbsm_pkg::sbsm_dec_t dec [sbsm_pkg::NUM_MST];
  logic [5:0]          routable;

  always_comb begin
    logic [5:0] cand;
    logic [3:0] sel;
    cand      = 6'h00;
    sel       = 4'h0;
    next_busy = busy;
    for (int m = 0; m < sbsm_pkg::NUM_MST; m++) begin
      dec[m] = decode(mst_req[m].addr, remap_control_bit[m], boot_cap);
      // path must exist; only byte, half and word routed
      routable[m] = dec[m].ok && PATH[dec[m].slv][m] &&
                    (mst_req[m].size <= sbsm_pkg::SIZE_WORD);
      next_mst_rsp[m] = '{ack: 1'b0, err: 1'b0, rdata: mst_rsp[m].rdata};
      // unused area, missing path, both answered with error
      if (mst_req[m].req && !mst_rsp[m].ack && !routable[m]) begin
        next_mst_rsp[m] = '{ack: 1'b1, err: 1'b1, rdata: 32'h0000_0000};
      end
    end
    for (int s = 0; s < sbsm_pkg::NUM_SLV; s++) begin
      next_owner[s]   = owner[s];
      next_last[s]    = last[s];
      next_slv_req[s] = slv_req[s];
      cand            = 6'h00;
      sel             = 4'h0;
      if (busy[s]) begin
        if (slv_rsp[s].ack) begin
          next_busy[s]            = 1'b0;
          next_slv_req[s].req     = 1'b0;
          next_mst_rsp[owner[s]]  = '{ack: 1'b1, err: slv_rsp[s].err,
                                      rdata: slv_rsp[s].rdata};
        end
      end else begin
        for (int m = 0; m < sbsm_pkg::NUM_MST; m++) begin
          cand[m] = mst_req[m].req && !mst_rsp[m].ack && routable[m] &&
                    (int'(dec[m].slv) == s);
        end
        sel = pick(cand, last[s], ARB_FIXED[s]);
        // each slave grants independently, so masters run concurrently
        if (sel[3]) begin
          next_busy[s]    = 1'b1;
          next_owner[s]   = sel[2:0];
          next_last[s]    = sel[2:0];
          next_slv_req[s] = mst_req[sel[2:0]];
          next_slv_req[s].req = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 6'h00;
      for (int s = 0; s < sbsm_pkg::NUM_SLV; s++) begin
        owner[s]   <= 3'h0;
        last[s]    <= sbsm_pkg::LAST_RST;
        slv_req[s] <= '0;
      end
      for (int m = 0; m < sbsm_pkg::NUM_MST; m++) begin
        mst_rsp[m] <= '0;
      end
    end else begin
      busy <= next_busy;
      for (int s = 0; s < sbsm_pkg::NUM_SLV; s++) begin
        owner[s]   <= next_owner[s];
        last[s]    <= next_last[s];
        slv_req[s] <= next_slv_req[s];
      end
      for (int m = 0; m < sbsm_pkg::NUM_MST; m++) begin
        mst_rsp[m] <= next_mst_rsp[m];
      end
    end
  end

endmodule

// >>> dv/sbsm_matrix_monitor.sv
module sbsm_matrix_monitor (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  wire logic           boot_select_level,
  input  wire logic [5:0]     remap_control_bit,
  input  sbsm_pkg::sbsm_req_t mst_req [sbsm_pkg::NUM_MST],
  input  sbsm_pkg::sbsm_rsp_t mst_rsp [sbsm_pkg::NUM_MST],
  input  sbsm_pkg::sbsm_req_t slv_req [sbsm_pkg::NUM_SLV],
  input  sbsm_pkg::sbsm_rsp_t slv_rsp [sbsm_pkg::NUM_SLV]
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // routing and error answers
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_unmapped; mst_req[5].req && !mst_rsp[5].ack &&
    mst_req[5].addr[31:28] inside {[4'h9:4'hE]} |=> mst_rsp[5].ack && mst_rsp[5].err; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped bank not refused");
  property p_lcd_dma; mst_req[0].req && !mst_rsp[0].ack &&
    mst_req[0].addr[31:20] == 12'h005 |=> mst_rsp[0].ack && mst_rsp[0].err; endproperty
  a_lcd_dma: assert property (p_lcd_dma) else $error("dma reached lcd config");
  property p_usb_brg; mst_req[1].req && !mst_rsp[1].ack &&
    mst_req[1].addr[31:28] == 4'hF |=> mst_rsp[1].ack && mst_rsp[1].err; endproperty
  a_usb_brg: assert property (p_usb_brg) else $error("usb dma reached bridge");
  property p_err_data; mst_rsp[5].err |-> mst_rsp[5].ack && mst_rsp[5].rdata == 32'h0; endproperty
  a_err_data: assert property (p_err_data) else $error("error answer malformed");
  property p_brg_bank; slv_req[5].req |-> slv_req[5].addr[31:28] == 4'hF; endproperty
  a_brg_bank: assert property (p_brg_bank) else $error("bridge got foreign bank");
  property p_ext_bank; slv_req[4].req |->
    slv_req[4].addr[31:28] inside {[4'h1:4'h8]} || slv_req[4].addr[31:20] == 12'h0; endproperty
  a_ext_bank: assert property (p_ext_bank) else $error("external port got foreign bank");
  property p_remap; $rose(mst_req[4].req) && mst_req[4].addr == 32'h0000_0010 &&
    remap_control_bit[4] |=> slv_req[1].req; endproperty
  a_remap: assert property (p_remap) else $error("remapped zero not on sram");
  property p_conc; $rose(mst_req[4].req) && $rose(mst_req[5].req) &&
    mst_req[4].addr[31:28] == 4'h1 && mst_req[5].addr[31:20] == 12'h001
    |=> slv_req[4].req && slv_req[1].req; endproperty
  a_conc: assert property (p_conc) else $error("parallel transfers serialised");
  cover property (slv_req[4].req && slv_req[1].req);
  cover property (mst_rsp[5].ack && mst_rsp[5].err);
  cover property (slv_req[5].req && slv_rsp[5].ack);
endmodule

bind sbsm_matrix sbsm_matrix_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b),
  .boot_select_level(boot_select_level), .remap_control_bit(remap_control_bit),
  .mst_req(mst_req), .mst_rsp(mst_rsp), .slv_req(slv_req), .slv_rsp(slv_rsp));

// >>> dv/sbsm_slave_model.sv
module sbsm_slave_model #(
  parameter logic [2:0] SLV  = 3'h0,
  parameter int         WAIT = 0
) (
  input  wire logic           ref_clk,
  input  wire logic           rst_b,
  input  sbsm_pkg::sbsm_req_t req,
  output sbsm_pkg::sbsm_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt;
  logic        ack;
  logic [31:0] word;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
    end else begin
      cnt <= req.req ? cnt + 1 : 0;
    end
  end
  assign word = {req.write, req.size, ^req.wdata, SLV, req.addr[23:0]};
  assign ack  = req.req && cnt == WAIT;
  // data line shows the inverse outside the answer cycle
  assign rsp  = '{ack, 1'b0, ack ? word : ~word};
endmodule

// >>> dv/sbsm_matrix_tb_top.sv
module sbsm_matrix_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk;
  logic                rst_b;
  logic                boot_select_level;
  logic [5:0]          remap_control_bit;
  sbsm_pkg::sbsm_req_t mst_req [sbsm_pkg::NUM_MST];
  sbsm_pkg::sbsm_rsp_t mst_rsp [sbsm_pkg::NUM_MST];
  sbsm_pkg::sbsm_req_t slv_req [sbsm_pkg::NUM_SLV];
  sbsm_pkg::sbsm_rsp_t slv_rsp [sbsm_pkg::NUM_SLV];
  int                  errors;
  int                  samples_checked;
  int                  cyc;
  // ----------------------------------------------------------------
  // matrix with usb dma cut from the bridge, fixed priority on sram
  // ----------------------------------------------------------------
  sbsm_matrix #(.PATH_PER_BRG(6'h05), .ARB_FIXED(6'h02)) dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .boot_select_level(boot_select_level), .remap_control_bit(remap_control_bit),
    .mst_req(mst_req), .mst_rsp(mst_rsp), .slv_req(slv_req), .slv_rsp(slv_rsp));
  for (genvar s = 0; s < 6; s++) begin : g_slv
    sbsm_slave_model #(.SLV(3'(s)), .WAIT(s == 4 ? 2 : 0)) u_slv (.ref_clk(ref_clk),
      .rst_b(rst_b), .req(slv_req[s]), .rsp(slv_rsp[s]));
  end
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input int m, input logic [31:0] a, input logic [2:0] sz,
                      input logic [2:0] es, input logic eok);
    int n;
    @(posedge ref_clk);
    mst_req[m] <= '{1'b1, a[4], sz, a, ~a};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (mst_rsp[m].ack !== 1'b1 && n < 50);
    mst_req[m].req <= 1'b0;
    chk({31'h0, mst_rsp[m].ack}, 32'h0000_0001);
    chk({31'h0, mst_rsp[m].err}, {31'h0, !eok});
    chk(mst_rsp[m].rdata, eok ? {a[4], sz, ^(~a), es, a[23:0]} : 32'h0);
  endtask
  task automatic t_map();
    xfer(5, 32'h0010_0000, 3'h0, 3'h1, 1'b1);
    xfer(5, 32'h0040_0002, 3'h1, 3'h0, 1'b1);
    xfer(5, 32'h0050_0000, 3'h2, 3'h2, 1'b1);
    xfer(5, 32'h0060_0000, 3'h2, 3'h3, 1'b1);
    xfer(5, 32'h1000_0000, 3'h2, 3'h4, 1'b1);
    xfer(5, 32'h8FFF_FFFC, 3'h2, 3'h4, 1'b1);
    xfer(5, 32'h9000_0000, 3'h2, 3'h0, 1'b0);
    xfer(5, 32'hE000_0000, 3'h2, 3'h0, 1'b0);
    xfer(5, 32'h0070_0000, 3'h2, 3'h0, 1'b0);
    xfer(5, 32'h0010_0000, 3'h3, 3'h1, 1'b0);
  endtask
  task automatic t_paths();
    for (int m = 0; m < 6; m++) begin
      xfer(m, 32'h0020_0000, 3'h2, 3'h1, 1'b1);
      xfer(m, 32'h0050_0000, 3'h2, 3'h2, m > 3);
      xfer(m, 32'h0060_0000, 3'h2, 3'h3, m > 3);
      xfer(m, 32'hF000_0100, 3'h2, 3'h5, m == 0 || m == 2);
    end
    xfer(2, 32'h0040_0000, 3'h2, 3'h0, 1'b0);
  endtask
  task automatic t_remap();
    xfer(4, 32'h0000_0010, 3'h2, 3'h0, 1'b1);
    remap_control_bit <= 6'h10;
    xfer(4, 32'h0000_0010, 3'h2, 3'h1, 1'b1);
    xfer(5, 32'h0000_0010, 3'h2, 3'h0, 1'b1);
    remap_control_bit <= 6'h00;
  endtask
  task automatic race(input logic [31:0] a, input logic [2:0] s, input logic [31:0] win);
    xfer(3, a, 3'h2, s, 1'b1);
    fork
      xfer(2, a + 32'h10, 3'h2, s, 1'b1);
      xfer(4, a + 32'h20, 3'h2, s, 1'b1);
      begin
        repeat (3) @(posedge ref_clk);
        chk(slv_req[s].addr, win);
      end
    join
  endtask
  task automatic t_conc();
    fork
      xfer(4, 32'h1000_0040, 3'h2, 3'h4, 1'b1);
      xfer(5, 32'h0010_0040, 3'h2, 3'h1, 1'b1);
    join
    race(32'h0010_0000, 3'h1, 32'h0010_0010);
    race(32'h2000_0000, 3'h4, 32'h2000_0020);
  endtask
  task automatic t_boot();
    @(posedge ref_clk);
    rst_b <= 1'b0;
    boot_select_level <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    xfer(5, 32'h0000_0010, 3'h2, 3'h4, 1'b1);
  endtask
  initial begin
    rst_b = 1'b0;
    boot_select_level = 1'b1;
    remap_control_bit = 6'h00;
    for (int m = 0; m < 6; m++) mst_req[m] = '0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_map();
    t_paths();
    t_remap();
    t_conc();
    t_boot();
    close_out();
  end
endmodule
